// >>> logic/controller_firmware_host_runtime_port.sv
// host runtime port of the embedded-controller mailbox, with word buffer
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`include "ec_port_defines.svh"

module ec_word_fifo #(
  parameter int WIDTH = `EC_FIFO_WIDTH,
  parameter int DEPTH = `EC_FIFO_DEPTH
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  // filling side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // draining side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] cnt;
    logic room;
    logic head_v;
    logic [WIDTH-1:0] head;
  } fifo_state_t;

  fifo_state_t st_r;
  fifo_state_t st_nxt;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop_mem;

  // head stage keeps the read data straight from a flop
  always_comb begin
    st_nxt = st_r;
    push = in_valid_in && st_r.room;
    pop_mem = (st_r.cnt != '0) && (!st_r.head_v || out_ready_in);
    if (push) begin
      st_nxt.wr_ptr = st_r.wr_ptr + 1'b1;
    end
    if (pop_mem) begin
      st_nxt.rd_ptr = st_r.rd_ptr + 1'b1;
      st_nxt.head = mem[st_r.rd_ptr];
      st_nxt.head_v = 1'b1;
    end else if (out_ready_in) begin
      st_nxt.head_v = 1'b0;
    end
    st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop_mem);
    st_nxt.room = (st_nxt.cnt + (AW+1)'(st_nxt.head_v) != (AW+1)'(DEPTH));
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_r <= '{room: 1'b1, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // storage carries no reset; only written words are ever read
  always_ff @(posedge core_clk_in) begin
    if (push) begin
      mem[st_r.wr_ptr] <= in_data_in;
    end
  end

  assign in_ready_out = st_r.room;
  assign out_valid_out = st_r.head_v;
  assign out_data_out = st_r.head;
endmodule : ec_word_fifo

module controller_firmware_host_runtime_port (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  // host register port
  input wire logic [15:0] host_base_in,
  input wire ec_port_pkg::bus_req_t host_req_in,
  output logic [7:0] host_rdata_out,
  // controller register port
  input wire ec_port_pkg::bus_req_t ctl_req_in,
  output logic [7:0] ctl_rdata_out,
  // host-to-controller word stream
  output logic stream_room_out,
  output logic stream_valid_out,
  input wire logic stream_ready_in,
  output ec_port_pkg::h2c_word_t stream_word_out,
  // mailbox flags
  output logic input_full_flag_out,
  output logic output_full_flag_out,
  output logic wide_mode_out
);
  import ec_port_pkg::*;

  port_state_t st_r;
  port_state_t st_nxt;
  logic [4:0] host_dec;
  logic [4:0] ctl_dec;
  logic h_rd;
  logic h_wr;
  logic [3:0] h_off;
  logic c_rd;
  logic c_wr;
  logic [3:0] c_off;
  logic h_lane_wr;
  logic h_cmd_wr;
  logic h_commit;
  logic c_obf_set;
  logic c_ibf_clr;
  logic fifo_ready;
  logic [`EC_FIFO_WIDTH-1:0] fifo_out;

  // returns {hit, offset}; both windows share this decode
  function automatic logic [4:0] win_dec(input logic [15:0] a,
                                         input logic [15:0] base,
                                         input logic [15:0] span);
    logic [15:0] d;
    d = a - base;
    win_dec = {(d < span), d[3:0]};
  endfunction : win_dec

  function automatic logic [7:0] status_byte(input port_state_t s);
    logic [7:0] b;
    b = s.sw_flags & `EC_ST_SW_MASK;
    b[`EC_ST_OBF] = s.output_full_flag;
    b[`EC_ST_IBF] = s.input_full_flag;
    b[`EC_ST_CMD] = s.cmd;
    status_byte = b;
  endfunction : status_byte

  always_comb begin
    host_dec = win_dec(host_req_in.addr, host_base_in, `EC_HOST_SPAN);
    ctl_dec = win_dec(ctl_req_in.addr, `EC_CTL_BASE, `EC_CTL_SPAN);
    h_off = host_dec[3:0];
    c_off = ctl_dec[3:0];
    h_rd = host_req_in.rd && host_dec[4];
    h_wr = host_req_in.wr && host_dec[4];
    c_rd = ctl_req_in.rd && ctl_dec[4];
    c_wr = ctl_req_in.wr && ctl_dec[4];
    h_lane_wr = h_wr && (h_off <= `EC_OFF_LANE3);
    h_cmd_wr = h_wr && (h_off == `EC_OFF_CMD_STAT);
    // the lane that closes a transfer depends on the mode
    h_commit = h_cmd_wr
      || (h_wr && !st_r.wide && h_off == `EC_OFF_LANE0)
      || (h_wr && st_r.wide && h_off == `EC_OFF_LANE3);
    c_obf_set = c_wr && (st_r.wide ? c_off == `EC_CTL_C2H0 + 4'h3
                                   : c_off == `EC_CTL_C2H0);
    c_ibf_clr = c_rd && (st_r.wide ? c_off == `EC_CTL_H2C0 + 4'h3
                                   : c_off == `EC_CTL_H2C0);
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.push_v = 1'b0;
    st_nxt.host_rdata = `EC_RST_BYTE;
    st_nxt.ctl_rdata = `EC_RST_BYTE;

    // controller side; clears come first so host sets win
    if (c_wr) begin
      if (c_off <= `EC_CTL_C2H0 + 4'h3) begin
        st_nxt.c2h[c_off[1:0]] = ctl_req_in.wdata;
      end
      if (c_off == `EC_CTL_STATUS) begin
        st_nxt.sw_flags = ctl_req_in.wdata & `EC_ST_SW_MASK;
      end
      if (c_off == `EC_CTL_BYTECTL) begin
        st_nxt.wide = ctl_req_in.wdata[`EC_BC_WIDE];
      end
    end
    if (c_obf_set) begin
      st_nxt.output_full_flag = 1'b1;
    end
    if (c_ibf_clr) begin
      st_nxt.input_full_flag = 1'b0;
    end
    if (c_rd) begin
      if (c_off <= `EC_CTL_C2H0 + 4'h3) begin
        st_nxt.ctl_rdata = st_r.c2h[c_off[1:0]];
      end else if (c_off == `EC_CTL_STATUS) begin
        st_nxt.ctl_rdata = status_byte(st_r);
      end else if (c_off == `EC_CTL_BYTECTL) begin
        st_nxt.ctl_rdata = {7'h00, st_r.wide};
      end else if (c_off >= `EC_CTL_H2C0) begin
        st_nxt.ctl_rdata = st_r.h2c[c_off[1:0]];
      end
    end

    // host side
    if (h_lane_wr) begin
      st_nxt.cmd = 1'b0;
      // upper lanes drop their data in legacy mode
      if (st_r.wide || h_off == `EC_OFF_LANE0) begin
        st_nxt.h2c[h_off[1:0]] = host_req_in.wdata;
      end
    end
    if (h_cmd_wr) begin
      st_nxt.h2c[0] = host_req_in.wdata;
      st_nxt.cmd = 1'b1;
    end
    if (h_commit) begin
      st_nxt.input_full_flag = 1'b1;
      st_nxt.push_v = 1'b1;
      st_nxt.push_word.is_cmd = h_cmd_wr;
      st_nxt.push_word.bytes = st_nxt.h2c;
    end
    if (h_rd) begin
      case (h_off)
        `EC_OFF_LANE0, `EC_OFF_LANE1, `EC_OFF_LANE2, `EC_OFF_LANE3: begin
          if (st_r.wide || h_off == `EC_OFF_LANE0) begin
            st_nxt.host_rdata = st_r.c2h[h_off[1:0]];
          end
        end
        `EC_OFF_CMD_STAT: begin
          st_nxt.host_rdata = status_byte(st_r);
        end
        `EC_OFF_BYTECTL: begin
          st_nxt.host_rdata = {7'h00, st_r.wide};
        end
        default: begin
          st_nxt.host_rdata = `EC_RST_BYTE;
        end
      endcase
      // a read that empties is overridden by a same-cycle set: set wins
      if ((!st_r.wide && h_off == `EC_OFF_LANE0 && !c_obf_set)
          || (st_r.wide && h_off == `EC_OFF_LANE3 && !c_obf_set)) begin
        st_nxt.output_full_flag = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // a commit while the buffer is full is lost; stream_room_out warns first
  ec_word_fifo #(
    .WIDTH(`EC_FIFO_WIDTH),
    .DEPTH(`EC_FIFO_DEPTH)
  ) u_word_fifo (
    .core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in),
    .in_valid_in(st_r.push_v),
    .in_ready_out(fifo_ready),
    .in_data_in(st_r.push_word),
    .out_valid_out(stream_valid_out),
    .out_ready_in(stream_ready_in),
    .out_data_out(fifo_out)
  );

  assign stream_room_out = fifo_ready;
  assign stream_word_out = h2c_word_t'(fifo_out);
  assign host_rdata_out = st_r.host_rdata;
  assign ctl_rdata_out = st_r.ctl_rdata;
  assign input_full_flag_out = st_r.input_full_flag;
  assign output_full_flag_out = st_r.output_full_flag;
  assign wide_mode_out = st_r.wide;

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!arst_n_in);

  sequence host_lane_wr_s(logic [3:0] n);
    host_req_in.wr && host_dec[4] && h_off == n;
  endsequence

  sequence host_lane_rd_s(logic [3:0] n);
    host_req_in.rd && host_dec[4] && h_off == n;
  endsequence

  sequence legacy_s;
    !st_r.wide;
  endsequence

  cmd_clear_on_data_a: assert property (
    h_lane_wr |=> !st_r.cmd)
    else $error("command flag survived a data lane write");

  legacy_ibf_set_a: assert property (
    (legacy_s and host_lane_wr_s(`EC_OFF_LANE0)) |=> st_r.input_full_flag
      && st_r.h2c[0] == $past(host_req_in.wdata))
    else $error("legacy lane 0 write did not fill input");

  legacy_obf_clear_a: assert property (
    (legacy_s and host_lane_rd_s(`EC_OFF_LANE0)) and !c_obf_set
      |=> !st_r.output_full_flag)
    else $error("legacy lane 0 read left output full");

  upper_write_drop_a: assert property (
    !st_r.wide && h_wr && h_off inside {[4'h1:4'h3]}
      |=> $stable(st_r.h2c[3:1]))
    else $error("legacy upper lane write was stored");

  upper_read_zero_a: assert property (
    !st_r.wide && h_rd && h_off inside {[4'h1:4'h3]}
      |=> host_rdata_out == 8'h00)
    else $error("legacy upper lane read not zero");

  upper_flags_hold_a: assert property (
    !st_r.wide && (h_rd || h_wr) && h_off inside {[4'h1:4'h3]}
      && !c_obf_set && !c_ibf_clr
      |=> $stable(st_r.input_full_flag) && $stable(st_r.output_full_flag))
    else $error("legacy upper lane access moved a flag");

  wide_ibf_set_a: assert property (
    (st_r.wide && h_wr && h_off == `EC_OFF_LANE3)
      |=> st_r.input_full_flag ##1 (st_r.input_full_flag || $past(c_ibf_clr)))
    else $error("wide lane 3 write did not fill input");

  wide_obf_clear_a: assert property (
    st_r.wide && h_rd && h_off == `EC_OFF_LANE3 && !c_obf_set
      |=> !st_r.output_full_flag)
    else $error("wide lane 3 read left output full");

  cmd_store_a: assert property (
    h_cmd_wr |=> st_r.h2c[0] == $past(host_req_in.wdata))
    else $error("command code not stored in byte 0");

  cmd_flags_a: assert property (
    h_cmd_wr |=> st_r.cmd && st_r.input_full_flag && st_r.push_v)
    else $error("command write did not set both flags");

  status_read_a: assert property (
    h_rd && h_off == `EC_OFF_CMD_STAT
      |=> host_rdata_out[`EC_ST_IBF] == $past(st_r.input_full_flag)
        && host_rdata_out[`EC_ST_OBF] == $past(st_r.output_full_flag))
    else $error("status read did not show the flags");

  lane_read_data_a: assert property (
    h_rd && h_off == `EC_OFF_LANE0
      |=> host_rdata_out == $past(st_r.c2h[0]))
    else $error("lane 0 read not from controller bytes");

  wide_mode_hold_a: assert property (
    !(c_wr && c_off == `EC_CTL_BYTECTL) |=> $stable(st_r.wide))
    else $error("transfer width changed without a write");

  wide_low_lanes_a: assert property (
    st_r.wide && h_wr && h_off <= `EC_OFF_LANE2 && !c_ibf_clr
      |=> $stable(st_r.input_full_flag) && st_r.h2c[$past(h_off[1:0])]
        == $past(host_req_in.wdata))
    else $error("wide low lane write misbehaved");
endmodule : controller_firmware_host_runtime_port

// >>> logic/ec_port_defines.svh
// offsets, field positions, reset values and sizes of the host runtime port
`ifndef EC_PORT_DEFINES_SVH
`define EC_PORT_DEFINES_SVH
// host window, relative to the programmed host base
`define EC_OFF_LANE0 4'h0
`define EC_OFF_LANE1 4'h1
`define EC_OFF_LANE2 4'h2
`define EC_OFF_LANE3 4'h3
`define EC_OFF_CMD_STAT 4'h4
`define EC_OFF_BYTECTL 4'h5
`define EC_HOST_SPAN 16'h0008
// controller window, relative to the fixed internal base
`define EC_CTL_BASE 16'h0100
`define EC_CTL_SPAN 16'h0010
`define EC_CTL_C2H0 4'h0
`define EC_CTL_STATUS 4'h4
`define EC_CTL_BYTECTL 4'h5
`define EC_CTL_H2C0 4'h8
// status and byte control fields
`define EC_ST_OBF 0
`define EC_ST_IBF 1
`define EC_ST_CMD 3
`define EC_ST_SW_MASK 8'hF4
`define EC_BC_WIDE 0
// reset values and buffer shape
`define EC_RST_BYTE 8'h00
`define EC_FIFO_DEPTH 32
`define EC_FIFO_WIDTH 33
`endif

// >>> logic/ec_port_pkg.sv
// types shared by the host runtime port, its bus master model and its bench
package ec_port_pkg;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } bus_req_t;

  typedef struct packed {
    logic is_cmd;
    logic [3:0][7:0] bytes;
  } h2c_word_t;

  typedef struct packed {
    logic [3:0][7:0] h2c;
    logic [3:0][7:0] c2h;
    logic [7:0] sw_flags;
    logic output_full_flag;
    logic input_full_flag;
    logic cmd;
    logic wide;
    logic [7:0] host_rdata;
    logic [7:0] ctl_rdata;
    logic push_v;
    h2c_word_t push_word;
  } port_state_t;
endpackage : ec_port_pkg

// >>> tb/bus_master_model.sv
// one-cycle strobe master for a byte register port (host or controller)
`timescale 1ns/1ps
module bus_master_model (
  // clock
  input wire logic core_clk_in,
  // register port
  output ec_port_pkg::bus_req_t req_out,
  input wire logic [7:0] rdata_in
);
  import ec_port_pkg::*;
  initial req_out = '0;
  // released address and data lines show the inverse of the last value, never a stale copy
  task automatic acc(input logic w, input logic [15:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    @(posedge core_clk_in);
    req_out <= '{rd: !w, wr: w, addr: a, wdata: d};
    @(posedge core_clk_in);
    req_out <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    #1;
    q = rdata_in;
  endtask : acc
endmodule : bus_master_model

// >>> tb/test_controller_firmware_host_runtime_port.sv
// self-checking bench of the host runtime port
`timescale 1ns/1ps
module test_controller_firmware_host_runtime_port;
  import ec_port_pkg::*;
  localparam logic [15:0] BASE = 16'h0620;
  logic [15:0] host_base = BASE;
  logic core_clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic stream_ready_in = 1'b1;
  bus_req_t host_req;
  bus_req_t ctl_req;
  logic [7:0] host_rdata;
  logic [7:0] ctl_rdata;
  logic room;
  logic valid;
  logic input_full_flag;
  logic output_full_flag;
  logic wide;
  h2c_word_t word;
  int bad_count = 0;
  int tests_run = 0;

  controller_firmware_host_runtime_port dut_u (
    .core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
    .host_base_in(host_base), .host_req_in(host_req),
    .host_rdata_out(host_rdata), .ctl_req_in(ctl_req),
    .ctl_rdata_out(ctl_rdata), .stream_room_out(room),
    .stream_valid_out(valid), .stream_ready_in(stream_ready_in),
    .stream_word_out(word), .input_full_flag_out(input_full_flag),
    .output_full_flag_out(output_full_flag), .wide_mode_out(wide));
  bus_master_model host_u (.core_clk_in(core_clk_in),
    .req_out(host_req), .rdata_in(host_rdata));
  bus_master_model ctl_u (.core_clk_in(core_clk_in),
    .req_out(ctl_req), .rdata_in(ctl_rdata));

  initial begin
    forever #2 core_clk_in = ~core_clk_in;
  end

  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic expect_word(input logic c, input logic [31:0] b);
    int k;
    k = 0;
    while (valid !== 1'b1 && k < 8) begin
      @(posedge core_clk_in);
      #1;
      k++;
    end
    tests_run++;
    if ({word.is_cmd, word.bytes} !== {c, b} || valid !== 1'b1) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time,
               {valid, word.is_cmd, word.bytes}, {1'b1, c, b});
    end
  endtask : expect_word

  task automatic hw(input logic [3:0] off, input logic [7:0] d);
    logic [7:0] q;
    host_u.acc(1'b1, host_base + 16'(off), d, q);
  endtask : hw

  task automatic hr(input logic [3:0] off, input logic [7:0] e);
    logic [7:0] q;
    host_u.acc(1'b0, host_base + 16'(off), 8'h00, q);
    check({1'b0, q}, {1'b0, e});
  endtask : hr

  task automatic cw(input logic [3:0] off, input logic [7:0] d);
    logic [7:0] q;
    ctl_u.acc(1'b1, 16'h0100 + 16'(off), d, q);
  endtask : cw

  task automatic cr(input logic [3:0] off, input logic [7:0] e);
    logic [7:0] q;
    ctl_u.acc(1'b0, 16'h0100 + 16'(off), 8'h00, q);
    check({1'b0, q}, {1'b0, e});
  endtask : cr

  task automatic flags(input logic i, input logic o);
    check({7'h00, input_full_flag, output_full_flag}, {7'h00, i, o});
  endtask : flags

  task automatic t_reset;
    for (int i = 0; i < 4; i++) hr(4'(i), 8'h00);
    hr(4'h4, 8'h00);
    hr(4'h5, 8'h00);
    check({8'h00, wide}, 9'h000);
    $display("done reset values");
  endtask : t_reset

  task automatic t_legacy;
    hw(4'h0, 8'hAA);
    flags(1'b1, 1'b0);
    expect_word(1'b0, 32'h000000AA);
    cr(4'h8, 8'hAA);
    flags(1'b0, 1'b0);
    hw(4'h4, 8'h5A);
    hr(4'h4, 8'h0A);
    cr(4'h8, 8'h5A);
    hw(4'h0, 8'h11);
    hr(4'h4, 8'h02);
    cr(4'h8, 8'h11);
    $display("done legacy byte 0");
  endtask : t_legacy

  task automatic t_upper;
    cw(4'h1, 8'h77);
    cw(4'h0, 8'h55);
    for (int i = 1; i < 4; i++) begin
      hw(4'(i), 8'hC0 + 8'(i));
      hr(4'(i), 8'h00);
      cr(4'h8 + 4'(i), 8'h00);
      flags(1'b0, 1'b1);
    end
    hr(4'h0, 8'h55);
    flags(1'b0, 1'b0);
    $display("done legacy upper lanes");
  endtask : t_upper

  task automatic t_wide;
    cw(4'h5, 8'h01);
    hr(4'h5, 8'h01);
    for (int i = 0; i < 3; i++) hw(4'(i), 8'h10 + 8'(i));
    flags(1'b0, 1'b0);
    hw(4'h3, 8'h13);
    flags(1'b1, 1'b0);
    expect_word(1'b0, 32'h13121110);
    for (int i = 0; i < 4; i++) cr(4'h8 + 4'(i), 8'h10 + 8'(i));
    flags(1'b0, 1'b0);
    for (int i = 0; i < 4; i++) cw(4'(i), 8'h20 + 8'(i));
    for (int i = 0; i < 3; i++) hr(4'(i), 8'h20 + 8'(i));
    flags(1'b0, 1'b1);
    hr(4'h3, 8'h23);
    flags(1'b0, 1'b0);
    hw(4'h4, 8'h33);
    hw(4'h1, 8'h44);
    hr(4'h4, 8'h02);
    cw(4'h5, 8'h00);
    cr(4'h8, 8'h33);
    flags(1'b0, 1'b0);
    $display("done wide mode");
  endtask : t_wide

  task automatic t_window;
    logic [7:0] q;
    hr(4'h6, 8'h00);
    hr(4'h7, 8'h00);
    hw(4'h8, 8'h99);
    // move the host window; the old base must no longer decode
    @(posedge core_clk_in);
    host_base <= 16'h0A40;
    host_u.acc(1'b1, BASE, 8'h98, q);
    flags(1'b0, 1'b0);
    hw(4'h0, 8'h66);
    flags(1'b1, 1'b0);
    cr(4'h8, 8'h66);
    cr(4'h6, 8'h00);
    @(posedge core_clk_in);
    host_base <= BASE;
    $display("done window decode");
  endtask : t_window

  task automatic t_fill;
    logic [7:0] n;
    n = 8'h00;
    @(posedge core_clk_in);
    stream_ready_in <= 1'b0;
    for (int i = 0; i < 32; i++) hw(4'h4, 8'(i));
    hw(4'h4, 8'hFF);
    repeat (3) @(posedge core_clk_in);
    #1;
    check({8'h00, room}, 9'h000);
    @(posedge core_clk_in);
    stream_ready_in <= 1'b1;
    for (int c = 0; c < 80; c++) begin
      #1;
      if (valid === 1'b1) begin
        check({word.is_cmd, word.bytes[0]}, {1'b1, n});
        n++;
      end
      @(posedge core_clk_in);
    end
    #1;
    check({1'b0, n}, 9'd32);
    check({7'h00, room, valid}, 9'h002);
    $display("done buffer fill and drain");
  endtask : t_fill

  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  // whole sequence needs well under 2000 cycles
  initial begin
    #100000;
    bad_count++;
    summarize();
  end

  initial begin
    repeat (5) @(posedge core_clk_in);
    arst_n_in <= 1'b1;
    @(posedge core_clk_in);
    t_reset();
    t_legacy();
    t_upper();
    t_wide();
    t_window();
    t_fill();
    summarize();
  end
endmodule : test_controller_firmware_host_runtime_port
